/* rtl/iac_pkg.sv */
package iac_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register bus map (byte addresses)
	localparam int         AXI_AW        = 8;
	localparam logic [7:0] OFF_CH1VOL    = 8'h00;
	localparam logic [7:0] OFF_CH2VOL    = 8'h04;
	localparam logic [7:0] OFF_ENHPROC   = 8'h08;
	localparam logic [7:0] OFF_ENHBASS   = 8'h0c;
	localparam logic [7:0] OFF_MUTETREB  = 8'h10;
	localparam logic [7:0] OFF_AGCSUR    = 8'h14;
	localparam logic [7:0] OFF_CTRL      = 8'h18;
	localparam logic [7:0] OFF_STATUS    = 8'h1c;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Serial link
	localparam logic [5:0] SLV_ADDR_HI   = 6'h20;
	localparam logic [2:0] SEL_CH1VOL    = 3'h0;
	localparam logic [2:0] SEL_CH2VOL    = 3'h1;
	localparam logic [2:0] SEL_ENHPROC   = 3'h2;
	localparam logic [2:0] SEL_ENHBASS   = 3'h3;
	localparam logic [2:0] SEL_MUTETREB  = 3'h4;
	localparam logic [2:0] SEL_AGCSUR    = 3'h5;
	localparam logic [2:0] SEL_NONE      = 3'h6;
	localparam logic [2:0] BIT_LAST      = 3'h7;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int BIT_AGC      = 7;
	localparam int BIT_SURON    = 6;
	localparam int BIT_STEREO   = 5;
	localparam int BIT_MONO     = 4;
	localparam int BIT_LOOP     = 3;
	localparam int EFF_MSB      = 2;
	localparam int BIT_ENH_EN   = 7;
	localparam int BIT_MUTE     = 7;
	localparam int TONE_MSB     = 6;
	localparam int PROC_MSB     = 7;
	localparam int PROC_LSB     = 4;
	localparam int CONT_MSB     = 3;
	localparam int BIT_CTRL_EN  = 0;
	localparam int BIT_ST_BUSY  = 0;
	localparam int ST_CNT_LSB   = 8;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and shifter stage counts
	localparam logic [7:0] RST_VOL       = 8'h00;
	localparam logic [7:0] RST_OTHER     = 8'h00;
	localparam logic       RST_CTRL_EN   = 1'b1;
	localparam logic [2:0] BASE_STAGES   = 3'h2;
	localparam logic [2:0] LOOP_STAGES   = 3'h4;

	typedef enum logic [2:0] {
		LS_IDLE, LS_ADDR, LS_ACKA, LS_SUBA, LS_ACKS, LS_DATA, LS_ACKD
	} iac_lstate_t;

	typedef struct packed {
		logic [7:0] ch1VolumeCtrl;
		logic [7:0] ch2VolumeCtrl;
		logic [3:0] enhProcess;
		logic [3:0] enhContour;
		logic       enhEnable;
		logic [6:0] bassLevel;
		logic       muteOn;
		logic [6:0] trebleLevel;
		logic       agcEnable;
		logic       surroundOn;
		logic       stereoSurroundSel;
		logic       monoSurroundSel;
		logic       loopEnable;
		logic [2:0] surroundEffect;
		logic [2:0] shifterStages;
	} iac_audio_t;

endpackage : iac_pkg

/* rtl/iac_sync.sv */
`timescale 1ns/100ps
module iac_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} iac_sync_st_t;

	iac_sync_st_t s_q;
	iac_sync_st_t s_d;

	always_comb begin
		s_d.meta = din;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	assign dout = s_q.sync;

endmodule : iac_sync

/* rtl/iac_top.sv */
`timescale 1ns/100ps
module iac_top (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire logic                         linkClk,
	input  wire logic                         sclIn,
	input  wire logic                         sdaIn,
	output logic                              sdaOut,
	output logic                              sdaOe,
	input  wire logic                         chipSel,
	output iac_pkg::iac_audio_t               audio,
	input  wire logic [iac_pkg::AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [iac_pkg::AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready
);

	////////////////////////////////////////////////////////////////////////////
	// Link domain state
	typedef struct packed {
		iac_pkg::iac_lstate_t st;
		logic [2:0]       bitCnt;
		logic [6:0]       shift;
		logic [2:0]       ptr;
		logic             ackOn;
		logic             sdaOe;
		logic             sdaOut;
		logic             sclP;
		logic             sdaP;
		logic [5:0][7:0]  regs;
		logic [5:0][7:0]  shadow;
		logic             dirty;
		logic             pend;
		logic             reqT;
	} iac_link_t;

	typedef struct packed {
		logic [5:0][7:0]  cap;
		iac_pkg::iac_audio_t audio;
		logic             ackT;
		logic             linkEn;
		logic [7:0]       updCnt;
		logic             awHave;
		logic [iac_pkg::AXI_AW-1:0] awAddr;
		logic             wHave;
		logic [31:0]      wData;
		logic [3:0]       wStrb;
		logic             awRdy;
		logic             wRdy;
		logic             bValid;
		logic [1:0]       bResp;
		logic             arRdy;
		logic             rValid;
		logic [31:0]      rData;
		logic [1:0]       rResp;
	} iac_host_t;

	iac_link_t l_q;
	iac_link_t l_d;
	iac_host_t h_q;
	iac_host_t h_d;

	logic       sclS;
	logic       sdaS;
	logic       csS;
	logic       enS;
	logic       ackS;
	logic       lrstN;
	logic       reqS;
	logic       busyS;
	logic       sclRise;
	logic       sclFall;
	logic       startDet;
	logic       stopDet;
	logic       byteDone;
	logic [7:0] dataByte;
	logic       addrMatch;

	////////////////////////////////////////////////////////////////////////////
	// Crossings
	iac_sync #(.W(6)) u_lsync (
		.clk  (linkClk),
		.din  ({sclIn, sdaIn, chipSel, h_q.linkEn, h_q.ackT, rst_n}),
		.dout ({sclS, sdaS, csS, enS, ackS, lrstN})
	);

	iac_sync #(.W(2)) u_hsync (
		.clk  (clk),
		.din  ({l_q.reqT, (l_q.st != iac_pkg::LS_IDLE)}),
		.dout ({reqS, busyS})
	);

	////////////////////////////////////////////////////////////////////////////
	// Link engine
	assign sclRise   = sclS && !l_q.sclP;
	assign sclFall   = !sclS && l_q.sclP;
	assign startDet  = sclS && l_q.sclP && l_q.sdaP && !sdaS;
	assign stopDet   = sclS && l_q.sclP && !l_q.sdaP && sdaS;
	assign byteDone  = sclRise && (l_q.bitCnt == iac_pkg::BIT_LAST);
	assign dataByte  = {l_q.shift, sdaS};
	assign addrMatch = (dataByte[7:2] == iac_pkg::SLV_ADDR_HI) && (dataByte[1] == csS) && !dataByte[0] && enS;

	always_comb begin
		l_d        = l_q;
		l_d.sclP   = sclS;
		l_d.sdaP   = sdaS;
		l_d.sdaOut = 1'b0;
		if (sclRise) begin
			l_d.shift  = dataByte[6:0];
			l_d.bitCnt = l_q.bitCnt + 3'h1;
		end
		unique case (l_q.st)
			iac_pkg::LS_IDLE: begin
				l_d.bitCnt = 3'h0;
			end
			iac_pkg::LS_ADDR: begin
				if (byteDone) begin
					l_d.st = addrMatch ? iac_pkg::LS_ACKA : iac_pkg::LS_IDLE;
				end
			end
			iac_pkg::LS_SUBA: begin
				if (byteDone) begin
					l_d.st  = iac_pkg::LS_ACKS;
					l_d.ptr = (dataByte > {5'h00, iac_pkg::SEL_AGCSUR}) ? iac_pkg::SEL_NONE : dataByte[2:0];
				end
			end
			iac_pkg::LS_DATA: begin
				if (byteDone) begin
					l_d.st = iac_pkg::LS_ACKD;
					if (l_q.ptr != iac_pkg::SEL_NONE) begin
						l_d.regs[l_q.ptr] = dataByte;
						l_d.dirty         = 1'b1;
					end
					if (l_q.ptr != iac_pkg::SEL_NONE) begin
						l_d.ptr = l_q.ptr + 3'h1;
					end
				end
			end
			iac_pkg::LS_ACKA, iac_pkg::LS_ACKS, iac_pkg::LS_ACKD: begin
				if (sclFall) begin
					l_d.ackOn  = !l_q.ackOn;
					l_d.sdaOe  = !l_q.ackOn;
					l_d.bitCnt = 3'h0;
					if (l_q.ackOn) begin
						l_d.st = (l_q.st == iac_pkg::LS_ACKA) ? iac_pkg::LS_SUBA : iac_pkg::LS_DATA;
					end
				end
			end
			default: begin
				l_d.st = iac_pkg::LS_IDLE;
			end
		endcase
		if (startDet) begin
			l_d.st     = iac_pkg::LS_ADDR;
			l_d.bitCnt = 3'h0;
			l_d.ackOn  = 1'b0;
			l_d.sdaOe  = 1'b0;
		end
		if (stopDet) begin
			l_d.st    = iac_pkg::LS_IDLE;
			l_d.ackOn = 1'b0;
			l_d.sdaOe = 1'b0;
		end
		if (l_q.pend && (ackS == l_q.reqT)) begin
			l_d.pend = 1'b0;
		end
		if (!l_q.pend && l_q.dirty) begin
			l_d.shadow = l_q.regs;
			l_d.reqT   = !l_q.reqT;
			l_d.pend   = 1'b1;
			l_d.dirty  = l_d.dirty && (l_q.st == iac_pkg::LS_DATA) && byteDone;
		end
		if (!lrstN) begin
			l_d        = '0;
			l_d.st     = iac_pkg::LS_IDLE;
			l_d.sclP   = 1'b1;
			l_d.sdaP   = 1'b1;
			l_d.reqT   = ackS;
			l_d.regs   = {6{iac_pkg::RST_OTHER}};
			l_d.regs[iac_pkg::SEL_CH1VOL] = iac_pkg::RST_VOL;
			l_d.regs[iac_pkg::SEL_CH2VOL] = iac_pkg::RST_VOL;
		end
	end

	always_ff @(posedge linkClk) begin
		l_q <= l_d;
	end

	assign sdaOe  = l_q.sdaOe;
	assign sdaOut = l_q.sdaOut;

	////////////////////////////////////////////////////////////////////////////
	// Host domain: capture and register bus
	always_comb begin
		logic [31:0] rd;
		logic [1:0]  rr;
		rd   = 32'h0000_0000;
		rr   = iac_pkg::RESP_OKAY;
		h_d  = h_q;
		if (reqS != h_q.ackT) begin
			h_d.cap    = l_q.shadow;
			h_d.ackT   = reqS;
			h_d.updCnt = h_q.updCnt + 8'h01;
		end
		if (s_axi_awvalid && h_q.awRdy) begin
			h_d.awHave = 1'b1;
			h_d.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && h_q.wRdy) begin
			h_d.wHave = 1'b1;
			h_d.wData = s_axi_wdata;
			h_d.wStrb = s_axi_wstrb;
		end
		if (h_q.bValid && s_axi_bready) begin
			h_d.bValid = 1'b0;
		end
		if (h_q.awHave && h_q.wHave && !h_q.bValid) begin
			h_d.awHave = 1'b0;
			h_d.wHave  = 1'b0;
			h_d.bValid = 1'b1;
			h_d.bResp  = (h_q.awAddr[7:5] == 3'h0) ? iac_pkg::RESP_OKAY : iac_pkg::RESP_SLVERR;
			if ((h_q.awAddr[7:2] == iac_pkg::OFF_CTRL[7:2]) && h_q.wStrb[0]) begin
				h_d.linkEn = h_q.wData[iac_pkg::BIT_CTRL_EN];
			end
		end
		unique case ({s_axi_araddr[7:2], 2'h0})
			iac_pkg::OFF_CH1VOL:   rd[7:0] = h_q.cap[iac_pkg::SEL_CH1VOL];
			iac_pkg::OFF_CH2VOL:   rd[7:0] = h_q.cap[iac_pkg::SEL_CH2VOL];
			iac_pkg::OFF_ENHPROC:  rd[7:0] = h_q.cap[iac_pkg::SEL_ENHPROC];
			iac_pkg::OFF_ENHBASS:  rd[7:0] = h_q.cap[iac_pkg::SEL_ENHBASS];
			iac_pkg::OFF_MUTETREB: rd[7:0] = h_q.cap[iac_pkg::SEL_MUTETREB];
			iac_pkg::OFF_AGCSUR:   rd[7:0] = h_q.cap[iac_pkg::SEL_AGCSUR];
			iac_pkg::OFF_CTRL:     rd[iac_pkg::BIT_CTRL_EN] = h_q.linkEn;
			iac_pkg::OFF_STATUS:   rd = {16'h0000, h_q.updCnt, 7'h00, busyS};
			default:               rr = iac_pkg::RESP_SLVERR;
		endcase
		if (h_q.rValid && s_axi_rready) begin
			h_d.rValid = 1'b0;
		end
		if (s_axi_arvalid && h_q.arRdy) begin
			h_d.rValid = 1'b1;
			h_d.rData  = rd;
			h_d.rResp  = rr;
		end
		if (!rst_n) begin
			h_d        = '0;
			h_d.linkEn = iac_pkg::RST_CTRL_EN;
			h_d.ackT   = reqS;
			h_d.cap    = {6{iac_pkg::RST_OTHER}};
			h_d.cap[iac_pkg::SEL_CH1VOL] = iac_pkg::RST_VOL;
			h_d.cap[iac_pkg::SEL_CH2VOL] = iac_pkg::RST_VOL;
		end
		h_d.awRdy = !h_d.awHave && !h_d.bValid && rst_n;
		h_d.wRdy  = !h_d.wHave && !h_d.bValid && rst_n;
		h_d.arRdy = !h_d.rValid && rst_n;
		h_d.audio.ch1VolumeCtrl     = h_d.cap[iac_pkg::SEL_CH1VOL];
		h_d.audio.ch2VolumeCtrl     = h_d.cap[iac_pkg::SEL_CH2VOL];
		h_d.audio.enhProcess        = h_d.cap[iac_pkg::SEL_ENHPROC][iac_pkg::PROC_MSB:iac_pkg::PROC_LSB];
		h_d.audio.enhContour        = h_d.cap[iac_pkg::SEL_ENHPROC][iac_pkg::CONT_MSB:0];
		h_d.audio.enhEnable         = h_d.cap[iac_pkg::SEL_ENHBASS][iac_pkg::BIT_ENH_EN];
		h_d.audio.bassLevel         = h_d.cap[iac_pkg::SEL_ENHBASS][iac_pkg::TONE_MSB:0];
		h_d.audio.muteOn            = h_d.cap[iac_pkg::SEL_MUTETREB][iac_pkg::BIT_MUTE];
		h_d.audio.trebleLevel       = h_d.cap[iac_pkg::SEL_MUTETREB][iac_pkg::TONE_MSB:0];
		h_d.audio.agcEnable         = h_d.cap[iac_pkg::SEL_AGCSUR][iac_pkg::BIT_AGC];
		h_d.audio.surroundOn        = h_d.cap[iac_pkg::SEL_AGCSUR][iac_pkg::BIT_SURON];
		h_d.audio.stereoSurroundSel = h_d.cap[iac_pkg::SEL_AGCSUR][iac_pkg::BIT_STEREO];
		h_d.audio.monoSurroundSel   = h_d.cap[iac_pkg::SEL_AGCSUR][iac_pkg::BIT_MONO];
		h_d.audio.loopEnable        = h_d.cap[iac_pkg::SEL_AGCSUR][iac_pkg::BIT_LOOP];
		h_d.audio.surroundEffect    = h_d.cap[iac_pkg::SEL_AGCSUR][iac_pkg::EFF_MSB:0];
		h_d.audio.shifterStages     = h_d.audio.loopEnable ? iac_pkg::LOOP_STAGES : iac_pkg::BASE_STAGES;
	end

	always_ff @(posedge clk) begin
		h_q <= h_d;
	end

	assign audio         = h_q.audio;
	assign s_axi_awready = h_q.awRdy;
	assign s_axi_wready  = h_q.wRdy;
	assign s_axi_bvalid  = h_q.bValid;
	assign s_axi_bresp   = h_q.bResp;
	assign s_axi_arready = h_q.arRdy;
	assign s_axi_rvalid  = h_q.rValid;
	assign s_axi_rdata   = h_q.rData;
	assign s_axi_rresp   = h_q.rResp;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_DATA_STAYS: assert property (@(posedge linkClk) disable iff (!lrstN)
		(l_q.st == iac_pkg::LS_ACKD && l_q.ackOn && sclFall && !startDet && !stopDet)
		|=> (l_q.st == iac_pkg::LS_DATA))
		else $error("data byte treated as select address");
	AST_VOL_FULL: assert property (@(posedge linkClk) disable iff (!lrstN)
		(l_q.st == iac_pkg::LS_DATA && byteDone && l_q.ptr == iac_pkg::SEL_CH2VOL && !startDet && !stopDet)
		|=> (l_q.regs[iac_pkg::SEL_CH2VOL] == $past(dataByte)))
		else $error("volume byte not stored whole");
	AST_TONE_SPLIT: assert property (@(posedge clk) disable iff (!rst_n)
		(audio.trebleLevel == h_q.cap[iac_pkg::SEL_MUTETREB][6:0]) && (audio.muteOn == h_q.cap[iac_pkg::SEL_MUTETREB][7]))
		else $error("treble field or mute bit misplaced");
	AST_VOL_RESET: assert property (@(posedge clk) disable iff (1'b0)
		(!rst_n ##1 rst_n) |-> (audio.ch1VolumeCtrl == 8'h00 && audio.ch2VolumeCtrl == 8'h00))
		else $error("volume not attenuated after reset");
	AST_LOOP_STAGE: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(audio.loopEnable) |-> (audio.shifterStages > $past(audio.shifterStages)))
		else $error("loop did not add shifter stages");
	AST_ADDR_NAK: assert property (@(posedge linkClk) disable iff (!lrstN)
		(l_q.st == iac_pkg::LS_ADDR && byteDone && dataByte[0] && !startDet && !stopDet)
		|=> (l_q.st == iac_pkg::LS_IDLE) [*2])
		else $error("read address was accepted");
	AST_SEL_MAP: assert property (@(posedge linkClk) disable iff (!lrstN)
		(l_q.st == iac_pkg::LS_DATA && byteDone && l_q.ptr == iac_pkg::SEL_ENHBASS && !startDet && !stopDet)
		|=> $stable(l_q.regs[iac_pkg::SEL_CH1VOL]) && (l_q.regs[iac_pkg::SEL_ENHBASS] == $past(dataByte)))
		else $error("select address mapped to wrong register");
	AST_NO_WRAP: assert property (@(posedge linkClk) disable iff (!lrstN)
		(l_q.st == iac_pkg::LS_DATA && byteDone && l_q.ptr == iac_pkg::SEL_AGCSUR && !startDet)
		|=> (l_q.ptr == iac_pkg::SEL_NONE))
		else $error("select address wrapped");
	AST_SUR_FIELDS: assert property (@(posedge clk) disable iff (!rst_n)
		{audio.agcEnable, audio.surroundOn, audio.stereoSurroundSel, audio.monoSurroundSel,
		 audio.loopEnable, audio.surroundEffect} == h_q.cap[iac_pkg::SEL_AGCSUR])
		else $error("surround register fields misplaced");
	AST_ACK_DRIVE: assert property (@(posedge linkClk) disable iff (!lrstN)
		(l_q.st == iac_pkg::LS_ADDR && byteDone && addrMatch && !startDet && !stopDet)
		|=> ##[0:300] l_q.sdaOe)
		else $error("matched address not acknowledged");
	AST_STOP_IDLE: assert property (@(posedge linkClk) disable iff (!lrstN)
		stopDet |=> (l_q.st == iac_pkg::LS_IDLE && !l_q.sdaOe))
		else $error("stop did not end transfer");

	COV_START:   cover property (@(posedge linkClk) disable iff (!lrstN) startDet);
	COV_AUTOINC: cover property (@(posedge linkClk) disable iff (!lrstN)
		(l_q.st == iac_pkg::LS_DATA && l_q.ptr == iac_pkg::SEL_AGCSUR));
	COV_CAPTURE: cover property (@(posedge clk) disable iff (!rst_n) (reqS != h_q.ackT));
	COV_AXIREAD: cover property (@(posedge clk) disable iff (!rst_n) (h_q.rValid && s_axi_rready));

endmodule : iac_top

/* verif/iac_i2c_master.sv */
`timescale 1ns/100ps
module iac_i2c_master #(
	parameter int Q = 4
) (
	input  wire logic linkClk,
	input  wire logic sdaWire,
	output logic      scl,
	output logic      sdaLow
);
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic tick();
		repeat (Q) @(posedge linkClk);
	endtask : tick
	task automatic put_bit(input logic b, output logic s);
		sdaLow <= ~b;
		tick();
		scl <= 1'b1;
		tick();
		s = sdaWire;
		tick();
		scl <= 1'b0;
		tick();
	endtask : put_bit
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(b[i], s);
		put_bit(1'b1, s);
		ack = (s === 1'b0);
	endtask : put_byte
	////////////////////////////////////////////////////////////////////////////
	// Address, one select, then data only
	task automatic frame(input logic cs, input logic rw, input logic [7:0] sel, input logic [7:0] d [8],
		input int n, output int acks);
		logic a;
		a = 1'b1;
		acks = 0;
		sdaLow <= 1'b1;
		tick();
		scl <= 1'b0;
		tick();
		for (int i = 0; i <= n + 1 && a; i++) begin
			put_byte(i == 0 ? {iac_pkg::SLV_ADDR_HI, cs, rw} : i == 1 ? sel : d[i-2], a);
			acks += int'(a);
		end
		sdaLow <= 1'b1;
		tick();
		scl <= 1'b1;
		tick();
		sdaLow <= 1'b0;
		tick();
	endtask : frame
endmodule : iac_i2c_master

/* verif/tb.sv */
`timescale 1ns/100ps
module tb;
	logic clk, rst_n, linkClk, chipSel, scl, sdaLow, sdaOut, sdaOe, sdaWire;
	iac_pkg::iac_audio_t audio;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] img [6];
	logic [7:0] dat [8];
	int n_errors, checked;
	assign sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));
	iac_top iac_top_inst (.clk(clk), .rst_n(rst_n), .linkClk(linkClk), .sclIn(scl), .sdaIn(sdaWire),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .chipSel(chipSel), .audio(audio), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	iac_i2c_master i2c_master_inst (.linkClk(linkClk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		linkClk = 1'b0;
		#1.3;
		forever #3 linkClk = ~linkClk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (i == 200) begin
			n_errors++;
			give_verdict();
		end
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (i == 200) begin
			n_errors++;
			give_verdict();
		end
	endtask : axi_read
	////////////////////////////////////////////////////////////////////////////
	task automatic chk();
		logic [31:0] d;
		logic [1:0] r;
		repeat (20) @(posedge clk);
		check(audio, {img[0], img[1], img[2], img[3], img[4], img[5],
			img[5][3] ? iac_pkg::LOOP_STAGES : iac_pkg::BASE_STAGES});
		for (int i = 0; i < 6; i++) begin
			axi_read(8'(4 * i), d, r);
			check({r, d}, {iac_pkg::RESP_OKAY, 24'h0, img[i]});
		end
	endtask : chk
	task automatic send(input logic cs, input logic rw, input logic [7:0] sel, input int n, input int expAcks);
		int acks;
		i2c_master_inst.frame(cs, rw, sel, dat, n, acks);
		check(acks, expAcks);
		for (int i = 0; i < n && expAcks > 0; i++)
			if (sel + i < 6)
				img[sel+i] = dat[i];
	endtask : send
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		check({audio.ch1VolumeCtrl, audio.ch2VolumeCtrl}, 16'h0);
		axi_read(iac_pkg::OFF_CTRL, d, r);
		check(d, 32'h1);
	endtask : t_reset
	task automatic t_auto();
		// First command mutes; loop with effect code 3
		dat = '{8'hff, 8'h01, 8'ha5, 8'hd5, 8'hbc, 8'h8b, 8'h12, 8'h34};
		send(1'b1, 1'b0, 8'h00, 8, 10);
		chk();
	endtask : t_auto
	task automatic t_incr();
		dat = '{8'h3e, 8'h04, 8'h47, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
		send(1'b1, 1'b0, 8'h01, 3, 5);
		chk();
	endtask : t_incr
	task automatic t_surround();
		// Stereo surround on before mode change
		dat[0] = 8'h63;
		send(1'b1, 1'b0, 8'h05, 1, 3);
		chk();
		dat[0] = 8'h53;
		send(1'b1, 1'b0, 8'h05, 1, 3);
		chk();
	endtask : t_surround
	task automatic t_addr();
		@(posedge clk);
		chipSel <= 1'b0;
		dat[0] = 8'h11;
		send(1'b1, 1'b0, 8'h00, 1, 0);
		send(1'b0, 1'b0, 8'h00, 1, 3);
		@(posedge clk);
		chipSel <= 1'b1;
		dat[0] = 8'h22;
		send(1'b1, 1'b1, 8'h00, 1, 0);
		chk();
	endtask : t_addr
	task automatic t_axi();
		logic [31:0] d;
		logic [1:0] r;
		axi_write(iac_pkg::OFF_CTRL, 32'h0, r);
		check(r, iac_pkg::RESP_OKAY);
		send(1'b1, 1'b0, 8'h00, 1, 0);
		axi_write(iac_pkg::OFF_CTRL, 32'h1, r);
		axi_write(iac_pkg::OFF_CH1VOL, 32'h55, r);
		check(r, iac_pkg::RESP_OKAY);
		axi_write(8'h24, 32'h0, r);
		check(r, iac_pkg::RESP_SLVERR);
		axi_read(8'h20, d, r);
		check({r, d}, {iac_pkg::RESP_SLVERR, 32'h0});
		axi_read(iac_pkg::OFF_STATUS, d, r);
		check(d[0], 1'b0);
		chk();
	endtask : t_axi
	////////////////////////////////////////////////////////////////////////////
	initial begin
		n_errors = 0;
		checked = 0;
		rst_n = 1'b0;
		chipSel = 1'b1;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		foreach (img[i])
			img[i] = 8'h00;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		t_reset();
		t_auto();
		t_incr();
		t_surround();
		t_addr();
		t_axi();
		give_verdict();
	end
endmodule : tb
